// [testbench/i2c_bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
   // wire levels seen by the block
   output logic scl,
   output logic sda
);
   // pulled-up idle bus, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // 7 ns skew keeps link edges off the core clock edge
   task automatic put_bit(input logic v);
      #7 sda = v;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #33;
   endtask
   task automatic start_cond();
      #7 sda = 1'b1;
      #40 scl = 1'b1;
      #40 sda = 1'b0;
      #40 scl = 1'b0;
      #33;
   endtask
   task automatic stop_cond();
      #7 sda = 1'b0;
      #40 scl = 1'b1;
      #40 sda = 1'b1;
      #33;
   endtask
   // msb first, acknowledge slot, then release to the pull-up
   task automatic send_byte(input logic [7:0] b, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i]);
      end
      put_bit(ack);
      sda = 1'b1;
   endtask
endmodule
`default_nettype wire

// [testbench/i2c_status_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_status_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // engine side
   input wire logic engine_busy,
   input wire logic [7:0] tx_holding_reg,
   input wire logic tx_load,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic tx_req;
   logic tx_take;
   logic [7:0] tx_byte;
   assign tx_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == i2c_status_pkg::tx_holding_addr;
   assign tx_take = tx_req && !engine_busy;
   assign tx_byte = wb_dat_i[7:0];
   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   AST_ACK_ONE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_TX_TAKE: assert property (
      tx_take |=> tx_load && tx_holding_reg == $past(tx_byte))
      else $error("idle tx write not taken");
   AST_TX_DROP: assert property (
      tx_req && engine_busy |=> !tx_load && $stable(tx_holding_reg))
      else $error("busy tx write not dropped");
   AST_TX_CAUSE: assert property (
      tx_load |-> $past(tx_take))
      else $error("tx load without idle write");
   AST_ST_ZERO: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == i2c_status_pkg::status_addr
      |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[13:11] == 3'h0)
      else $error("unused status bits not zero");
   AST_UNMAPPED: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_RESET_QUIET: assert property (
      $fell(reset) |-> !irq && !tx_load && !wb_ack_o)
      else $error("outputs active after reset");
endmodule
bind i2c_status_flag_logic i2c_status_sva chk (
   .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .engine_busy(engine_busy),
   .tx_holding_reg(tx_holding_reg), .tx_load(tx_load), .irq(irq));
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, tx_load, irq, scl_in, sda_in;
   logic own_sda_high = 1'b0, master_active = 1'b0, engine_busy = 1'b0;
   logic [4:0] evp = 5'h0;
   logic [7:0] rx_shift_reg = 8'h0, tx_holding_reg, rx_holding;
   logic [15:0] st = 16'h0000;
   logic [31:0] seed = 32'h9f0116c2;
   int fail_count = 0, checks_done = 0;
   always #10 core_clk = ~core_clk;
   i2c_bus_partner partner (.scl(scl_in), .sda(sda_in));
   i2c_status_flag_logic DUT (
      .core_clk(core_clk), .reset(reset),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .scl_in(scl_in), .sda_in(sda_in),
      .master_tx_start(evp[0]), .own_sda_high(own_sda_high), .master_active(master_active),
      .slave_addr_match(evp[1]), .ten_bit_second_match(evp[2]), .slave_byte_done(evp[3]),
      .rx_shift_reg(rx_shift_reg), .rx_holding_read(evp[4]), .engine_busy(engine_busy),
      .tx_holding_reg(tx_holding_reg), .tx_load(tx_load), .rx_holding_reg(rx_holding),
      .irq(irq));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // a zero write clears only the sticky bits
   function automatic logic [15:0] after_write(input logic [15:0] s, input logic [15:0] d);
      return s & ~(~d & 16'h04c0);
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   // master waits for ack, never assumes its latency
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 20) begin
         fail_count++;
         final_report();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic chk_st();
      wb(1'b0, i2c_status_pkg::status_addr, 32'h0);
      cmp(rd, {16'h0, st});
   endtask
   task automatic pulse(input logic [4:0] m);
      evp <= m;
      @(posedge core_clk);
      evp <= 5'h0;
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk_st();
      wb(1'b0, i2c_status_pkg::irq_mask_addr, 32'h0);
      cmp(rd, 32'h0);
      wb(1'b0, 4'h2, 32'h0);
      cmp(rd, 32'h0);
      wb(1'b1, i2c_status_pkg::status_addr, 32'hffff);
      chk_st();
      // idle write taken, busy write dropped
      seed = xs(seed);
      wb(1'b1, i2c_status_pkg::tx_holding_addr, seed);
      cmp(32'(tx_holding_reg), 32'(seed[7:0]));
      engine_busy <= 1'b1;
      wb(1'b1, i2c_status_pkg::tx_holding_addr, ~seed);
      engine_busy <= 1'b0;
      st[7] = 1'b1;
      cmp(32'(tx_holding_reg), 32'(seed[7:0]));
      chk_st();
      wb(1'b0, i2c_status_pkg::irq_status_addr, 32'h0);
      cmp(rd, 32'h2);
      cmp(32'(irq), 32'h0);
      wb(1'b1, i2c_status_pkg::irq_mask_addr, 32'h2);
      idle(2);
      cmp(32'(irq), 32'h1);
      wb(1'b1, i2c_status_pkg::irq_status_addr, 32'h2);
      idle(2);
      cmp(32'(irq), 32'h0);
      wb(1'b1, i2c_status_pkg::status_addr, 32'h0);
      st = after_write(st, 16'h0);
      chk_st();
      // collision sticky until a zero write
      partner.start_cond();
      master_active <= 1'b1;
      own_sda_high <= 1'b1;
      idle(8);
      partner.put_bit(1'b0);
      idle(8);
      master_active <= 1'b0;
      own_sda_high <= 1'b0;
      st[10] = 1'b1;
      chk_st();
      wb(1'b1, i2c_status_pkg::status_addr, 32'hffff);
      chk_st();
      wb(1'b1, i2c_status_pkg::status_addr, 32'h0);
      st = after_write(st, 16'h0);
      chk_st();
      for (int i = 1; i >= 0; i--) begin
         pulse(5'h01);
         st[14] = 1'b1;
         chk_st();
         seed = xs(seed);
         partner.send_byte(seed[7:0], i[0]);
         idle(8);
         st[14] = 1'b0;
         st[15] = i[0];
         chk_st();
      end
      // stop also ends a pending transmit
      pulse(5'h01);
      partner.stop_cond();
      idle(8);
      st[4] = 1'b1;
      chk_st();
      partner.start_cond();
      idle(8);
      st[4] = 1'b0;
      chk_st();
      // general call, ten-bit, address then data
      partner.send_byte(8'h00, 1'b0);
      idle(8);
      pulse(5'h08);
      pulse(5'h02);
      st[9] = 1'b1;
      chk_st();
      pulse(5'h04);
      st[8] = 1'b1;
      chk_st();
      seed = xs(seed);
      partner.send_byte(seed[7:0], 1'b0);
      idle(8);
      rx_shift_reg <= seed[7:0];
      pulse(5'h08);
      st[6] = 1'b1;
      st[5] = 1'b1;
      chk_st();
      // no overflow once the holding byte was read
      wb(1'b1, i2c_status_pkg::status_addr, 32'h0);
      st = after_write(st, 16'h0);
      pulse(5'h10);
      pulse(5'h08);
      chk_st();
      cmp(32'(rx_holding), 32'(seed[7:0]));
      partner.stop_cond();
      idle(8);
      st[9:8] = 2'b00;
      st[4] = 1'b1;
      chk_st();
      final_report();
   end
endmodule
`default_nettype wire

// [verilog/i2c_bus_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // synced line levels
   input wire logic scl,
   input wire logic sda,
   // conditions, one cycle each
   output logic start_seen,
   output logic stop_seen,
   output logic scl_rise,
   output logic scl_fall
);
   logic scl_d;
   logic sda_d;
   logic next_start;
   logic next_stop;
   logic next_rise;
   logic next_fall;

   always_comb begin
      next_start = scl && scl_d && sda_d && !sda;
      next_stop = scl && scl_d && !sda_d && sda;
      next_rise = scl && !scl_d;
      next_fall = !scl && scl_d;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
         scl_rise <= 1'b0;
         scl_fall <= 1'b0;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
         start_seen <= next_start;
         stop_seen <= next_stop;
         scl_rise <= next_rise;
         scl_fall <= next_fall;
      end
   end
endmodule
`default_nettype wire

// [verilog/i2c_status_flag_logic.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - master transmit ack slot end loads ack flag, 1 for nack, 0 ack
// - master tx active flag set at transmit start, cleared after ack slot
// - collision as master sets collision flag, held until software clears
// - general call address match sets flag, stop clears it
// - second byte of matched ten-bit address sets flag, stop clears it
// - tx holding write while busy is dropped and sets write collision
// - new byte while rx holding still full sets sticky overflow flag
// - slave address match clears data flag, received data byte sets it
// - stop flag follows last condition: one after stop, zero after start
module i2c_status_flag_logic (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // controller engine events, same clock
   input wire logic master_tx_start,
   input wire logic own_sda_high,
   input wire logic master_active,
   input wire logic slave_addr_match,
   input wire logic ten_bit_second_match,
   input wire logic slave_byte_done,
   input wire logic [7:0] rx_shift_reg,
   input wire logic rx_holding_read,
   input wire logic engine_busy,
   // outputs
   output logic [7:0] tx_holding_reg,
   output logic tx_load,
   output logic [7:0] rx_holding_reg,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   logic scl;
   logic sda;
   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;

   sync_two_ff scl_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(scl_in),
      .sync_out(scl)
   );
   sync_two_ff sda_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(sda_in),
      .sync_out(sda)
   );
   i2c_bus_monitor monitor (
      .core_clk(core_clk),
      .reset(reset),
      .scl(scl),
      .sda(sda),
      .start_seen(start_seen),
      .stop_seen(stop_seen),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {idle_s, data_s, ack_s} tx_state_t;

   tx_state_t tx_state;
   tx_state_t next_tx_state;
   logic [3:0] bit_count;
   logic [3:0] next_bit_count;
   logic [7:0] first_byte;
   logic [7:0] next_first_byte;
   logic first_pending;
   logic next_first_pending;
   logic [7:0] slave_shift;
   logic [7:0] next_slave_shift;
   logic [3:0] slave_count;
   logic [3:0] next_slave_count;
   logic ack_slot_end;
   logic ack_value;
   logic rx_full;
   logic next_rx_full;
   logic [7:0] next_rx_holding;
   logic [15:0] status;
   logic [15:0] next_status;
   logic [3:0] irq_status;
   logic [3:0] next_irq_status;
   logic [3:0] irq_mask;
   logic [3:0] next_irq_mask;
   logic [7:0] next_tx_holding;
   logic next_tx_load;
   logic [31:0] next_dat;
   logic next_ack;
   logic next_irq;
   logic bus_req;
   logic wr_req;
   logic [3:0] events;

   // request taken in cycle it first appears, ack one cycle later
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_req = bus_req && wb_we_i;

   function automatic logic hit(input logic [3:0] adr, input logic [3:0] reg_adr);
      hit = (adr == reg_adr);
   endfunction

   // last data bit index: the ack slot follows this falling clock
   function automatic logic [3:0] byte_bits_m1();
      byte_bits_m1 = i2c_status_pkg::byte_bits - 4'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // ack slot tracker and slave byte sampler
   always_comb begin
      next_tx_state = tx_state;
      next_bit_count = bit_count;
      ack_slot_end = 1'b0;
      next_first_byte = first_byte;
      next_first_pending = first_pending;
      next_slave_shift = slave_shift;
      next_slave_count = slave_count;
      if (start_seen || stop_seen) begin
         next_slave_count = 4'h0;
         next_first_pending = 1'b1;
      end else if (scl_rise) begin
         if (slave_count == i2c_status_pkg::byte_bits) begin
            next_slave_count = 4'h0;
         end else begin
            next_slave_count = slave_count + 4'h1;
         end
         if (slave_count != i2c_status_pkg::byte_bits) begin
            next_slave_shift = {slave_shift[6:0], sda};
         end
      end
      if (slave_byte_done && first_pending) begin
         next_first_byte = slave_shift;
         next_first_pending = 1'b0;
      end
      case (tx_state)
         idle_s: begin
            if (master_tx_start) begin
               next_tx_state = data_s;
               next_bit_count = 4'h0;
            end
         end
         data_s: begin
            if (scl_fall) begin
               next_bit_count = bit_count + 4'h1;
               if (bit_count == byte_bits_m1()) begin
                  next_tx_state = ack_s;
               end
            end
         end
         ack_s: begin
            // slot ends on the falling clock after ack sample
            if (scl_fall) begin
               ack_slot_end = 1'b1;
               next_tx_state = idle_s;
            end
         end
         default: next_tx_state = idle_s;
      endcase
      if (stop_seen) begin
         next_tx_state = idle_s;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_state <= idle_s;
         bit_count <= 4'h0;
         first_byte <= 8'h00;
         first_pending <= 1'b1;
         slave_shift <= 8'h00;
         slave_count <= 4'h0;
      end else begin
         tx_state <= next_tx_state;
         bit_count <= next_bit_count;
         first_byte <= next_first_byte;
         first_pending <= next_first_pending;
         slave_shift <= next_slave_shift;
         slave_count <= next_slave_count;
      end
   end

   // sda sampled on the ack clock high phase
   logic ack_sample;
   logic next_ack_sample;
   always_comb begin
      next_ack_sample = ack_sample;
      if (tx_state == ack_s && scl_rise) begin
         next_ack_sample = sda;
      end
      ack_value = ack_sample;
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_sample <= 1'b0;
      end else begin
         ack_sample <= next_ack_sample;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, hardware set wins over software clear
   always_comb begin
      next_status = status;
      next_rx_full = rx_full;
      next_rx_holding = rx_holding_reg;
      next_tx_holding = tx_holding_reg;
      next_tx_load = 1'b0;
      events = 4'h0;
      if (rx_holding_read) begin
         next_rx_full = 1'b0;
      end
      // zero write clears only clearable bits
      if (wr_req && hit(wb_adr_i, i2c_status_pkg::status_addr)) begin
         if (wb_sel_i[1] && !wb_dat_i[i2c_status_pkg::collision_bit]) begin
            next_status[i2c_status_pkg::collision_bit] = 1'b0;
         end
         if (wb_sel_i[0]) begin
            if (!wb_dat_i[i2c_status_pkg::write_col_bit]) begin
               next_status[i2c_status_pkg::write_col_bit] = 1'b0;
            end
            if (!wb_dat_i[i2c_status_pkg::overflow_bit]) begin
               next_status[i2c_status_pkg::overflow_bit] = 1'b0;
            end
         end
      end
      if (wr_req && hit(wb_adr_i, i2c_status_pkg::tx_holding_addr) && wb_sel_i[0]) begin
         if (engine_busy) begin
            next_status[i2c_status_pkg::write_col_bit] = 1'b1;
            events[i2c_status_pkg::ev_write_col] = 1'b1;
         end else begin
            next_tx_holding = wb_dat_i[7:0];
            next_tx_load = 1'b1;
         end
      end
      if (ack_slot_end) begin
         next_status[i2c_status_pkg::ack_result_bit] = ack_value;
      end
      if (master_tx_start) begin
         next_status[i2c_status_pkg::master_tx_bit] = 1'b1;
      end else if (ack_slot_end || stop_seen) begin
         next_status[i2c_status_pkg::master_tx_bit] = 1'b0;
      end
      if (master_active && own_sda_high && !sda && scl_rise) begin
         next_status[i2c_status_pkg::collision_bit] = 1'b1;
         events[i2c_status_pkg::ev_collision] = 1'b1;
      end
      if (stop_seen) begin
         next_status[i2c_status_pkg::general_call_bit] = 1'b0;
      end else if (slave_byte_done && first_pending
                   && slave_shift == i2c_status_pkg::general_call_byte) begin
         next_status[i2c_status_pkg::general_call_bit] = 1'b1;
      end
      if (stop_seen) begin
         next_status[i2c_status_pkg::ten_bit_bit] = 1'b0;
      end else if (ten_bit_second_match) begin
         next_status[i2c_status_pkg::ten_bit_bit] = 1'b1;
      end
      if (slave_addr_match) begin
         next_status[i2c_status_pkg::data_addr_bit] = 1'b0;
      end else if (slave_byte_done) begin
         next_status[i2c_status_pkg::data_addr_bit] = 1'b1;
      end
      if (slave_byte_done) begin
         if (rx_full && !rx_holding_read) begin
            next_status[i2c_status_pkg::overflow_bit] = 1'b1;
            events[i2c_status_pkg::ev_overflow] = 1'b1;
         end else begin
            next_rx_holding = rx_shift_reg;
            next_rx_full = 1'b1;
         end
      end
      if (stop_seen) begin
         next_status[i2c_status_pkg::stop_bit] = 1'b1;
         events[i2c_status_pkg::ev_stop] = 1'b1;
      end else if (start_seen) begin
         next_status[i2c_status_pkg::stop_bit] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt and bus answer
   always_comb begin
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      if (wr_req && hit(wb_adr_i, i2c_status_pkg::irq_status_addr) && wb_sel_i[0]) begin
         next_irq_status = irq_status & ~wb_dat_i[3:0];
      end
      next_irq_status = next_irq_status | events;
      if (wr_req && hit(wb_adr_i, i2c_status_pkg::irq_mask_addr) && wb_sel_i[0]) begin
         next_irq_mask = wb_dat_i[3:0];
      end
      next_irq = |(next_irq_status & next_irq_mask);
      next_ack = bus_req;
      next_dat = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         if (hit(wb_adr_i, i2c_status_pkg::status_addr)) begin
            next_dat = {16'h0000, status};
         end else if (hit(wb_adr_i, i2c_status_pkg::irq_status_addr)) begin
            next_dat = {28'h0000000, irq_status};
         end else if (hit(wb_adr_i, i2c_status_pkg::irq_mask_addr)) begin
            next_dat = {28'h0000000, irq_mask};
         end else if (hit(wb_adr_i, i2c_status_pkg::tx_holding_addr)) begin
            next_dat = {24'h000000, tx_holding_reg};
         end else begin
            next_dat = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status <= i2c_status_pkg::status_reset;
         rx_full <= 1'b0;
         rx_holding_reg <= 8'h00;
         tx_holding_reg <= 8'h00;
         tx_load <= 1'b0;
         irq_status <= i2c_status_pkg::irq_reset;
         irq_mask <= i2c_status_pkg::irq_reset;
         irq <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         status <= next_status;
         rx_full <= next_rx_full;
         rx_holding_reg <= next_rx_holding;
         tx_holding_reg <= next_tx_holding;
         tx_load <= next_tx_load;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end
endmodule
`default_nettype wire

// [verilog/i2c_status_pkg.sv]
package i2c_status_pkg;
   // wishbone byte addresses
   localparam logic [3:0] status_addr = 4'h0;
   localparam logic [3:0] irq_status_addr = 4'h4;
   localparam logic [3:0] irq_mask_addr = 4'h8;
   localparam logic [3:0] tx_holding_addr = 4'hc;
   // status field positions
   localparam int ack_result_bit = 15;
   localparam int master_tx_bit = 14;
   localparam int collision_bit = 10;
   localparam int general_call_bit = 9;
   localparam int ten_bit_bit = 8;
   localparam int write_col_bit = 7;
   localparam int overflow_bit = 6;
   localparam int data_addr_bit = 5;
   localparam int stop_bit = 4;
   // event bits of the interrupt status
   localparam int ev_collision = 0;
   localparam int ev_write_col = 1;
   localparam int ev_overflow = 2;
   localparam int ev_stop = 3;
   localparam int ev_count = 4;
   // reset values
   localparam logic [15:0] status_reset = 16'h0000;
   localparam logic [3:0] irq_reset = 4'h0;
   // general call address
   localparam logic [7:0] general_call_byte = 8'h00;
   // bits per byte on the wire
   localparam logic [3:0] byte_bits = 4'h8;
endpackage

// [verilog/sync_two_ff.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // async level in, synced level out
   input wire logic async_in,
   output logic sync_out
);
   logic first;
   logic next_first;
   logic next_sync;

   always_comb begin
      next_first = async_in;
      next_sync = first;
   end

   // reset high: an idle two-wire line is released high
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         first <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         first <= next_first;
         sync_out <= next_sync;
      end
   end
endmodule
`default_nettype wire
